// ---- rtl/dpr_pkg.sv ----
// Constants, encodings and helper functions shared by the dual-port RAM and FIFO block.
`default_nettype none
package dpr_pkg;

	// ****************************************************************
	// Register map and field positions
	// ****************************************************************
	localparam int APB_AW = 12;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_THR = 12'h004;
	localparam logic [11:0] ADDR_STAT = 12'h008;
	localparam logic [11:0] ADDR_WGRAY = 12'h00c;
	localparam logic [11:0] ADDR_RGRAY = 12'h010;

	localparam int CTRL_FIFO = 0;
	localparam int CTRL_PIPE = 1;
	localparam int CTRL_WFALL = 2;
	localparam int CTRL_RFALL = 3;
	localparam int CTRL_WSEL_LSB = 4;
	localparam int CTRL_RSEL_LSB = 8;
	localparam int CTRL_FRST = 16;
	localparam int THR_AF_LSB = 0;
	localparam int THR_AE_LSB = 8;
	localparam int STAT_EMPTY = 0;
	localparam int STAT_FULL = 1;
	localparam int STAT_ALMOST_EMPTY_FLAG = 2;
	localparam int STAT_ALMOST_FULL_FLAG = 3;
	localparam int STAT_FILL_LEVEL_DIFFERENCE_LSB = 8;

	// ****************************************************************
	// Reset values and geometry
	// ****************************************************************
	localparam logic [2:0] WSEL_RESET = 3'h5;
	localparam logic [7:0] THR_RESET = 8'h00;
	localparam int DATA_W = 36;
	localparam int LANE_W = 9;
	localparam int BASE_PTR_BITS = 12;
	localparam int FILL_LEVEL_DIFFERENCE_CMP_LSB = 8;
	localparam int THR_W = 8;
	localparam int SYNC_STAGES = 2;

	// Width select codes; the code equals the pointer step exponent.
	typedef enum logic [2:0] {
		DPR_W1,
		DPR_W2,
		DPR_W4,
		DPR_W9,
		DPR_W18,
		DPR_W36
	} dpr_width_t;

	// Unused select codes fall back to the widest word.
	function automatic logic [2:0] width_shift(input logic [2:0] code);
		width_shift = (code > 3'(DPR_W36)) ? 3'(DPR_W36) : code;
	endfunction

	function automatic logic [35:0] width_mask(input logic [2:0] code);
		unique case (width_shift(code))
			3'(DPR_W1): width_mask = 36'h0_0000_0001;
			3'(DPR_W2): width_mask = 36'h0_0000_0003;
			3'(DPR_W4): width_mask = 36'h0_0000_000f;
			3'(DPR_W9): width_mask = 36'h0_0000_01ff;
			3'(DPR_W18): width_mask = 36'h0_0003_ffff;
			default: width_mask = 36'hf_ffff_ffff;
		endcase
	endfunction

endpackage
`default_nettype wire

// ---- rtl/dpr_sync.sv ----
// Two-stage synchroniser for a bundle of pin inputs.
`default_nettype none
module dpr_sync #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] meta_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			dout <= '0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end

endmodule
`default_nettype wire

// ---- rtl/dpr_ram_fifo.sv ----
// Dual-port RAM with embedded FIFO controller and APB configuration registers.
//
// The APB register port and the register addresses were decided locally.
`default_nettype none
// Summary of operation
// RL1: Lower address maps to lower data bits.
// RL2: Each port picks rising or falling edge.
// RL3: Address width follows aspect ratio and cascade.
// RL4: Port data width is 1,2,4,9,18,36.
// RL5: Read enable at edge returns addressed word.
// RL6: Write enable at edge stores data.
// RL7: Separate three-bit width selects per port.
// RL8: Unpipelined read shows data next cycle.
// RL9: Pipelined read adds one more edge.
// RL10: Read and write ports never stall each other.
// RL11: FIFO pushes and pops on enabled edges.
// RL12: Full flag on write side blocks writes.
// RL13: Empty flag on read side blocks reads.
// RL14: Pointers cross as Gray codes.
// RL15: FIFO reset returns to empty state.
// RL16: Organisations from 4k x 1 to 128 x 36.
// RL17: Pointer bits 11..5 always active.
// RL18: Inactive pointer bits held at zero.
// RL19: Upper pointer bits select cascaded block.
// RL20: Eight-bit almost thresholds drive almost flags.
// RL21: Difference bits from 8 compare thresholds.
// RL22: Almost full at or above, empty below; the code sets almost empty at or below the threshold.
// RL23: Blocked accesses change nothing stored.
module dpr_ram_fifo #(
	parameter int CASCADE_LOG2 = 0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic write_clock,
	input wire logic write_enable,
	input wire logic [12+CASCADE_LOG2-1:0] write_address_bus,
	input wire logic [35:0] write_data_bus,
	input wire logic read_clock,
	input wire logic read_enable,
	input wire logic [12+CASCADE_LOG2-1:0] read_address_bus,
	output logic [35:0] read_data_bus,
	output logic full_flag,
	output logic empty_flag,
	output logic almost_full_flag,
	output logic almost_empty_flag
);

	// RL16 depth from cascade
	localparam int PW = dpr_pkg::BASE_PTR_BITS + CASCADE_LOG2;
	localparam int LW = PW - 3;
	localparam int LANES = 1 << LW;
	localparam int CW = PW - dpr_pkg::FILL_LEVEL_DIFFERENCE_CMP_LSB;
	localparam logic [PW+1:0] CAP = (PW+2)'(1) << PW;

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	logic fifo_q, pipe_q, wfall_q, rfall_q, frst_q;
	logic [2:0] wsel_q, rsel_q;
	logic [7:0] afth_q, aeth_q;
	logic [PW:0] wptr_q, rptr_q, wgray_q, rgray_q;
	logic [PW:0] wptr_d, rptr_d, wdiff, rdiff;
	logic [31:0] rd_mux;
	logic addr_ok, setup, access;

	assign setup = psel & ~penable;
	assign access = psel & penable & pready;
	assign addr_ok = (paddr == dpr_pkg::ADDR_CTRL) || (paddr == dpr_pkg::ADDR_THR) ||
		(paddr == dpr_pkg::ADDR_STAT) || (paddr == dpr_pkg::ADDR_WGRAY) ||
		(paddr == dpr_pkg::ADDR_RGRAY);

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			dpr_pkg::ADDR_CTRL: begin
				rd_mux[dpr_pkg::CTRL_FIFO] = fifo_q;
				rd_mux[dpr_pkg::CTRL_PIPE] = pipe_q;
				rd_mux[dpr_pkg::CTRL_WFALL] = wfall_q;
				rd_mux[dpr_pkg::CTRL_RFALL] = rfall_q;
				rd_mux[dpr_pkg::CTRL_WSEL_LSB +: 3] = wsel_q;
				rd_mux[dpr_pkg::CTRL_RSEL_LSB +: 3] = rsel_q;
			end
			dpr_pkg::ADDR_THR: begin
				rd_mux[dpr_pkg::THR_AF_LSB +: 8] = afth_q;
				rd_mux[dpr_pkg::THR_AE_LSB +: 8] = aeth_q;
			end
			dpr_pkg::ADDR_STAT: begin
				rd_mux[dpr_pkg::STAT_EMPTY] = empty_flag;
				rd_mux[dpr_pkg::STAT_FULL] = full_flag;
				rd_mux[dpr_pkg::STAT_ALMOST_EMPTY_FLAG] = almost_empty_flag;
				rd_mux[dpr_pkg::STAT_ALMOST_FULL_FLAG] = almost_full_flag;
				rd_mux[dpr_pkg::STAT_FILL_LEVEL_DIFFERENCE_LSB +: 17] = 17'(wdiff);
			end
			dpr_pkg::ADDR_WGRAY: rd_mux = 32'(wgray_q);
			dpr_pkg::ADDR_RGRAY: rd_mux = 32'(rgray_q);
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Zero wait states: the answer is prepared during the setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (setup) begin
			pready <= 1'b1;
			pslverr <= ~addr_ok;
			prdata <= (addr_ok && !pwrite) ? rd_mux : 32'h0000_0000;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
	end

	// RL7 width selects written
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fifo_q <= 1'b0;
			pipe_q <= 1'b0;
			wfall_q <= 1'b0;
			rfall_q <= 1'b0;
			wsel_q <= dpr_pkg::WSEL_RESET;
			rsel_q <= dpr_pkg::WSEL_RESET;
			afth_q <= dpr_pkg::THR_RESET;
			aeth_q <= dpr_pkg::THR_RESET;
			frst_q <= 1'b0;
		end else begin
			frst_q <= 1'b0;
			if (access && pwrite && !pslverr && paddr == dpr_pkg::ADDR_CTRL) begin
				fifo_q <= pwdata[dpr_pkg::CTRL_FIFO];
				pipe_q <= pwdata[dpr_pkg::CTRL_PIPE];
				wfall_q <= pwdata[dpr_pkg::CTRL_WFALL];
				rfall_q <= pwdata[dpr_pkg::CTRL_RFALL];
				wsel_q <= pwdata[dpr_pkg::CTRL_WSEL_LSB +: 3];
				rsel_q <= pwdata[dpr_pkg::CTRL_RSEL_LSB +: 3];
				frst_q <= pwdata[dpr_pkg::CTRL_FRST];
			end
			if (access && pwrite && !pslverr && paddr == dpr_pkg::ADDR_THR) begin
				afth_q <= pwdata[dpr_pkg::THR_AF_LSB +: 8];
				aeth_q <= pwdata[dpr_pkg::THR_AE_LSB +: 8];
			end
		end
	end

	// ****************************************************************
	// Port pins and active edge detection
	// ****************************************************************
	logic ws_clk, ws_en, rs_clk, rs_en, wclk_prev_q, rclk_prev_q, wr_evt, rd_evt;
	logic [PW-1:0] ws_addr, rs_addr;
	logic [35:0] ws_data;

	// RL10 independent port paths
	dpr_sync #(.W(2 + PW + 36)) u_wsync (
		.pclk(pclk),
		.presetn(presetn),
		.din({write_clock, write_enable, write_address_bus, write_data_bus}),
		.dout({ws_clk, ws_en, ws_addr, ws_data})
	);

	dpr_sync #(.W(2 + PW)) u_rsync (
		.pclk(pclk),
		.presetn(presetn),
		.din({read_clock, read_enable, read_address_bus}),
		.dout({rs_clk, rs_en, rs_addr})
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wclk_prev_q <= 1'b0;
			rclk_prev_q <= 1'b0;
		end else begin
			wclk_prev_q <= ws_clk;
			rclk_prev_q <= rs_clk;
		end
	end

	// RL2 edge select
	assign wr_evt = wfall_q ? (~ws_clk & wclk_prev_q) : (ws_clk & ~wclk_prev_q);
	assign rd_evt = rfall_q ? (~rs_clk & rclk_prev_q) : (rs_clk & ~rclk_prev_q);

	// ****************************************************************
	// Storage and location mapping
	// ****************************************************************
	logic [8:0] mem [LANES];
	logic [2:0] shw, shr;
	logic [PW-1:0] w_loc, r_loc;
	logic [LW-1:0] w_lane, r_lane;
	logic [35:0] w_mask, w_bits, r_cat, rd_word, stage_q;
	logic w_do, r_do;
	assign shw = dpr_pkg::width_shift(wsel_q);
	assign shr = dpr_pkg::width_shift(rsel_q);
	// RL3 address scaling
	// RL17 step by width
	assign w_loc = fifo_q ? wptr_q[PW-1:0] : PW'(ws_addr << shw);
	assign r_loc = fifo_q ? rptr_q[PW-1:0] : PW'(rs_addr << shr);
	// RL19 block select bits
	assign w_lane = w_loc[PW-1:3];
	assign r_lane = r_loc[PW-1:3];
	// RL1 little endian placement
	assign w_mask = dpr_pkg::width_mask(wsel_q) << w_loc[2:0];
	assign w_bits = (ws_data & dpr_pkg::width_mask(wsel_q)) << w_loc[2:0];
	assign r_cat = {mem[r_lane + LW'(3)], mem[r_lane + LW'(2)], mem[r_lane + LW'(1)],
		mem[r_lane]};
	// RL4 width masking
	assign rd_word = (r_cat >> r_loc[2:0]) & dpr_pkg::width_mask(rsel_q);

	// RL23 blocked accesses
	assign w_do = wr_evt & ws_en & ~(fifo_q & full_flag);
	assign r_do = rd_evt & rs_en & ~(fifo_q & empty_flag);

	// RL6 store on write edge
	always_ff @(posedge pclk) begin
		for (int i = 0; i < 4; i++) begin
			if (w_do && w_mask[i*9 +: 9] != 9'h000) begin
				mem[w_lane + LW'(i)] <= (mem[w_lane + LW'(i)] & ~w_mask[i*9 +: 9]) |
					(w_bits[i*9 +: 9] & w_mask[i*9 +: 9]);
			end
		end
	end

	// RL5 addressed read
	// RL8 direct output
	// RL9 extra pipeline edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_q <= 36'h0_0000_0000;
			read_data_bus <= 36'h0_0000_0000;
		end else begin
			if (r_do) begin
				stage_q <= rd_word;
			end
			if (rd_evt && pipe_q) begin
				read_data_bus <= stage_q;
			end else if (r_do) begin
				read_data_bus <= rd_word;
			end
		end
	end

	// ****************************************************************
	// FIFO pointers and flags
	// ****************************************************************
	function automatic logic [PW:0] gray2bin(input logic [PW:0] g);
		logic [PW:0] b;
		b[PW] = g[PW];
		for (int i = PW - 1; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction
	logic [PW:0] step_w, step_r;
	logic [CW-1:0] wcmp, rcmp;
	logic [PW+1:0] w_need;

	assign step_w = (PW+1)'(1) << shw;
	assign step_r = (PW+1)'(1) << shr;
	// RL11 push and pop
	assign wptr_d = (fifo_q && w_do) ? wptr_q + step_w : wptr_q;
	assign rptr_d = (fifo_q && r_do) ? rptr_q + step_r : rptr_q;
	// RL14 peer seen through Gray
	assign wdiff = wptr_d - (gray2bin(rgray_q) & ~(step_r - (PW+1)'(1)));
	assign rdiff = (gray2bin(wgray_q) & ~(step_w - (PW+1)'(1))) - rptr_d;
	assign w_need = {1'b0, wdiff} + {1'b0, step_w};
	// RL21 compare window
	assign wcmp = wdiff[PW] ? '1 : wdiff[PW-1:dpr_pkg::FILL_LEVEL_DIFFERENCE_CMP_LSB];
	assign rcmp = rdiff[PW] ? '1 : rdiff[PW-1:dpr_pkg::FILL_LEVEL_DIFFERENCE_CMP_LSB];

	// RL15 reset to empty
	// RL18 low bits stay zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr_q <= '0;
			rptr_q <= '0;
			wgray_q <= '0;
			rgray_q <= '0;
		end else if (frst_q) begin
			wptr_q <= '0;
			rptr_q <= '0;
			wgray_q <= '0;
			rgray_q <= '0;
		end else begin
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
			// Only active bits are Gray coded, so each step flips one bit.
			wgray_q <= wptr_d ^ ((wptr_d >> 1) & ~(step_w - (PW+1)'(1)));
			rgray_q <= rptr_d ^ ((rptr_d >> 1) & ~(step_r - (PW+1)'(1)));
		end
	end

	// RL12 full on write side
	// RL13 empty on read side
	// RL20 almost flags
	// RL22 threshold compare
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			full_flag <= 1'b0;
			empty_flag <= 1'b1;
			almost_full_flag <= 1'b0;
			almost_empty_flag <= 1'b1;
		end else if (frst_q) begin
			full_flag <= 1'b0;
			empty_flag <= 1'b1;
			almost_full_flag <= 1'b0;
			almost_empty_flag <= 1'b1;
		end else begin
			full_flag <= w_need > CAP;
			empty_flag <= rdiff < step_r;
			almost_full_flag <= wcmp >= afth_q[CW-1:0];
			almost_empty_flag <= rcmp <= aeth_q[CW-1:0];
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_full_blocks_write: assert property ( // RL12
		@(posedge pclk) disable iff (!presetn)
		(fifo_q && full_flag && wr_evt && !frst_q) |=> (wptr_q == $past(wptr_q)))
		else $error("write pointer moved while full");

	a_empty_blocks_read: assert property ( // RL13
		@(posedge pclk) disable iff (!presetn)
		(fifo_q && empty_flag && rd_evt && !frst_q) |=> (rptr_q == $past(rptr_q)))
		else $error("read pointer moved while empty");

	a_gray_one_bit: assert property ( // RL14
		@(posedge pclk) disable iff (!presetn)
		(!$past(frst_q) && $changed(wgray_q)) |-> ($countones(wgray_q ^ $past(wgray_q)) == 1))
		else $error("write gray pointer changed more than one bit");

	a_reset_empties: assert property ( // RL15
		@(posedge pclk) disable iff (!presetn)
		frst_q |=> (empty_flag && !full_flag && wptr_q == '0 && rptr_q == '0))
		else $error("fifo reset did not return to empty");

	a_no_overflow: assert property ( // RL23
		@(posedge pclk) disable iff (!presetn)
		fifo_q |-> ((wptr_q - rptr_q) <= CAP[PW:0]))
		else $error("fifo fill level exceeded capacity");

	a_inactive_zero: assert property ( // RL18
		@(posedge pclk) disable iff (!presetn)
		(fifo_q && $stable(wsel_q) && $stable(fifo_q)) |->
			((wptr_q & (step_w - (PW+1)'(1))) == '0))
		else $error("inactive low pointer bit set");

	a_pipe_delay: assert property ( // RL9
		@(posedge pclk) disable iff (!presetn)
		(pipe_q && rd_evt) |=> (read_data_bus == $past(stage_q)))
		else $error("pipelined read did not show staged word");

	a_direct_read: assert property ( // RL8
		@(posedge pclk) disable iff (!presetn)
		(!pipe_q && r_do) |=> (read_data_bus == $past(rd_word)) ##1 $stable(read_data_bus))
		else $error("unpipelined read data not held after the edge");

	a_almost_full_flag_level: assert property ( // RL22
		@(posedge pclk) disable iff (!presetn)
		(!frst_q && wcmp >= afth_q[CW-1:0]) |=> almost_full_flag)
		else $error("almost full flag missing at threshold");
endmodule
`default_nettype wire

// ---- dv/dpr_user_model.sv ----
// Model of the user logic that drives the write and read ports of the block.
`default_nettype none
module dpr_user_model #(
	parameter int AW = 12
) (
	input wire logic pclk,
	output logic write_clock,
	output logic write_enable,
	output logic [AW-1:0] write_address_bus,
	output logic [35:0] write_data_bus,
	output logic read_clock,
	output logic read_enable,
	output logic [AW-1:0] read_address_bus
);
	timeunit 1ns;
	timeprecision 1ps;

	// Pin clocks idle low so that the release of reset shows no active edge.
	initial begin
		write_clock = 1'b0;
		write_enable = 1'b0;
		write_address_bus = '0;
		write_data_bus = '0;
		read_clock = 1'b0;
		read_enable = 1'b0;
		read_address_bus = '0;
	end

	// ****************************************************************
	// Port operations
	// ****************************************************************
	// held write.
	task automatic wr(input logic [AW-1:0] a, input logic [35:0] d);
		@(posedge pclk);
		write_enable <= 1'b1;
		write_address_bus <= a;
		write_data_bus <= d;
		repeat (3) @(posedge pclk);
		write_clock <= 1'b1;
		repeat (3) @(posedge pclk);
		write_clock <= 1'b0;
		repeat (3) @(posedge pclk);
		// Released lines show the inverse so that a stale value cannot pass.
		write_enable <= 1'b0;
		write_address_bus <= ~a;
		write_data_bus <= ~d;
		repeat (3) @(posedge pclk);
	endtask

	task automatic rd(input logic [AW-1:0] a);
		@(posedge pclk);
		read_enable <= 1'b1;
		read_address_bus <= a;
		repeat (3) @(posedge pclk);
		read_clock <= 1'b1;
		repeat (3) @(posedge pclk);
		read_clock <= 1'b0;
		repeat (3) @(posedge pclk);
		read_enable <= 1'b0;
		read_address_bus <= ~a;
		repeat (3) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

// ---- dv/dpr_ram_fifo_tb_top.sv ----
// Self-checking bench for the dual-port RAM and FIFO block.
`default_nettype none
module dpr_ram_fifo_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [11:0] a;
		logic [35:0] d;
	} dpr_row_t;

	localparam logic [35:0] LANES = {9'h0e4, 9'h1c3, 9'h0a2, 9'h101};
	logic pclk = 1'b0;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic write_clock;
	logic write_enable;
	logic [11:0] write_address_bus;
	logic [35:0] write_data_bus;
	logic read_clock;
	logic read_enable;
	logic [11:0] read_address_bus;
	logic [35:0] read_data_bus;
	logic full_flag;
	logic empty_flag;
	logic almost_full_flag;
	logic almost_empty_flag;
	logic [31:0] r;
	logic e;
	int error_cnt = 0;
	int samples_checked = 0;
	dpr_row_t rows [5] = '{
		'{32'h550, 12'h000, 36'h0_0000_0001},
		'{32'h550, 12'h07f, 36'hf_ffff_ffff},
		'{32'h55c, 12'h040, 36'h5_a5a5_a5a5},
		'{32'h55c, 12'h001, 36'ha_5a5a_5a5a},
		'{32'h440, 12'h010, 36'h0_0002_b3c5}
	};

	always #5 pclk = ~pclk;

	dpr_ram_fifo dpr_ram_fifo_i (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .write_clock, .write_enable, .write_address_bus, .write_data_bus,
		.read_clock, .read_enable, .read_address_bus, .read_data_bus, .full_flag,
		.empty_flag, .almost_full_flag, .almost_empty_flag
	);

	dpr_user_model dpr_user_model_i (
		.pclk, .write_clock, .write_enable, .write_address_bus, .write_data_bus,
		.read_clock, .read_enable, .read_address_bus
	);

	// ****************************************************************
	// Bus cycles and comparisons
	// ****************************************************************
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic note(input logic ok, input string what);
		samples_checked++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("ERROR %0t: %s mismatch", $time, what);
		end
	endtask

	task automatic chk_data(input logic [35:0] exp);
		note(read_data_bus === exp, "read data");
	endtask

	task automatic chk_flags(input logic [3:0] exp);
		note({full_flag, empty_flag, almost_full_flag, almost_empty_flag} === exp, "flags");
	endtask

	task automatic chk_reg(input logic [31:0] exp, input logic err);
		note(r === exp && e === err, "register");
	endtask

	task automatic results();
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (10000) @(posedge pclk);
		error_cnt++;
		$display("ERROR %0t: timeout", $time);
		results();
	end

	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial begin
		presetn <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 12'h000;
		pwdata <= 32'h0000_0000;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		chk_flags(4'b0111);
		chk_data(36'h0);
		apb(1'b0, dpr_pkg::ADDR_CTRL, 32'h0);
		chk_reg(32'h550, 1'b0);
		apb(1'b0, dpr_pkg::ADDR_STAT, 32'h0);
		chk_reg(32'hd, 1'b0);
		apb(1'b1, 12'h014, 32'hffff_ffff);
		chk_reg(32'h0, 1'b1);
		foreach (rows[i]) begin
			apb(1'b1, dpr_pkg::ADDR_CTRL, rows[i].ctrl);
			dpr_user_model_i.wr(rows[i].a, rows[i].d);
		end
		foreach (rows[i]) begin
			apb(1'b1, dpr_pkg::ADDR_CTRL, rows[i].ctrl);
			dpr_user_model_i.rd(rows[i].a);
			chk_data(rows[i].d);
		end
		apb(1'b1, dpr_pkg::ADDR_CTRL, 32'h552);
		dpr_user_model_i.rd(12'h000);
		chk_data(rows[4].d);
		dpr_user_model_i.rd(12'h07f);
		chk_data(rows[0].d);
		apb(1'b1, dpr_pkg::ADDR_CTRL, 32'h530);
		for (int i = 0; i < 4; i++) begin
			dpr_user_model_i.wr(12'(8 + i), {27'h0, LANES[9*i +: 9]});
		end
		dpr_user_model_i.rd(12'h002);
		chk_data(LANES);
		apb(1'b1, dpr_pkg::ADDR_CTRL, 32'h030);
		dpr_user_model_i.rd(12'h040);
		chk_data(36'h1);
		dpr_user_model_i.rd(12'h041);
		chk_data(36'h0);
		apb(1'b1, dpr_pkg::ADDR_THR, 32'h0108);
		apb(1'b1, dpr_pkg::ADDR_CTRL, 32'h551);
		for (int i = 1; i <= 129; i++) begin
			dpr_user_model_i.wr(12'h000, 36'h100 + 36'(i));
			case (i)
				1: apb(1'b0, dpr_pkg::ADDR_WGRAY, 32'h0);
				15: chk_flags(4'b0001);
				16, 63: chk_flags(4'b0000);
				64: chk_flags(4'b0010);
				128, 129: chk_flags(4'b1010);
				default: ;
			endcase
			if (i == 1) chk_reg(32'h20, 1'b0);
		end
		for (int i = 1; i <= 128; i++) begin
			dpr_user_model_i.rd(12'h000);
			chk_data(36'h100 + 36'(i));
		end
		chk_flags(4'b0101);
		dpr_user_model_i.rd(12'h000);
		chk_data(36'h180);
		dpr_user_model_i.wr(12'h000, 36'h1);
		chk_flags(4'b0001);
		apb(1'b1, dpr_pkg::ADDR_CTRL, 32'h10551);
		repeat (2) @(posedge pclk);
		chk_flags(4'b0101);
		apb(1'b0, dpr_pkg::ADDR_WGRAY, 32'h0);
		chk_reg(32'h0, 1'b0);
		apb(1'b0, dpr_pkg::ADDR_CTRL, 32'h0);
		chk_reg(32'h551, 1'b0);
		presetn <= 1'b0;
		@(posedge pclk);
		chk_flags(4'b0101);
		chk_data(36'h0);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		chk_flags(4'b0111);
		apb(1'b0, dpr_pkg::ADDR_CTRL, 32'h0);
		chk_reg(32'h550, 1'b0);
		results();
	end
endmodule
`default_nettype wire
